// ==== pis_pkg.sv ====
// constants for the interrupt select and power management capability words
package pis_pkg;
  localparam logic [7:0]  OFF_CAP_PTR        = 8'h34;
  localparam logic [7:0]  OFF_INT_SELECT     = 8'h3c;
  localparam logic [7:0]  OFF_PM_CAP         = 8'h40;

  localparam logic [7:0]  MAX_LATENCY_RST    = 8'h34;
  localparam logic [7:0]  MIN_GRANT_RST      = 8'h0b;
  localparam logic [7:0]  INT_PIN_CODE       = 8'h01;
  localparam logic [7:0]  INT_LINE_RST       = 8'h00;
  localparam logic [31:0] INT_SELECT_RST     = 32'h340b0100;
  localparam logic [31:0] PM_CAP_RST         = 32'hff820001;

  localparam int          MAX_LAT_LSB        = 24;
  localparam int          MIN_GNT_LSB        = 16;
  localparam int          INT_PIN_LSB        = 8;
  localparam int          INT_LINE_LSB       = 0;

  localparam int          WAKE_LSB           = 27;
  localparam int          STATE_TWO_BIT      = 26;
  localparam int          STATE_ONE_BIT      = 25;
  localparam int          AUX_CUR_LSB        = 22;
  localparam int          PM_VER_LSB         = 16;
  localparam int          NEXT_PTR_LSB       = 8;
  localparam int          CAP_ID_LSB         = 0;

  localparam logic [3:0]  WAKE_WARM_STATES   = 4'hf;
  localparam logic        WAKE_COLD_RST      = 1'b1;
  localparam logic        AUX_OK_RST         = 1'b1;
  localparam logic [2:0]  AUX_CURRENT_MAX    = 3'h6;
  localparam logic [2:0]  AUX_CURRENT_NONE   = 3'h0;
  localparam logic [2:0]  PM_SPEC_VERSION    = 3'h2;
  localparam logic [7:0]  NEXT_CAP_POINTER   = 8'h00;
  localparam logic [7:0]  CAP_IDENTIFIER     = 8'h01;
  localparam logic [7:0]  CAP_LIST_OFFSET    = 8'h40;
  localparam int          CAP_LIST_EN_BIT    = 4;

  typedef struct packed {
    logic [7:0]  max_latency_desired;
    logic [7:0]  min_grant_desired;
    logic [7:0]  interrupt_line_number;
    logic        wake_cold_stored;
    logic [2:0]  aux_sync;
    logic        aux_ok;
    logic [31:0] rdata;
    logic        rvalid;
  } pis_state_t;
endpackage

// ==== pis_cfg_regs.sv ====
// interrupt select and power management capability configuration words
//
// Behaviour
// - max latency resets to decimal 52
// - min grant resets to decimal 11
// - eeprom load overwrites latency and grant
// - interrupt pin byte reads constant 01h
// - host writes line number, reads it back
// - hard reset 340b0100h, soft reset keeps
// - capability word visible only with bit4
// - wake field, one bit per state
// - cold wake reported only with aux power
// - cold wake bit loadable while in D3cold
// - bit 26 reads 1, D2 supported
// - bit 25 reads 1, D1 supported
// - aux current 110b if cold wake, else 000b
// - version field reads 010b
// - next capability pointer reads 00h
// - capability identifier reads 01h
// - capability list offset reads 40h
`timescale 1ns/1ns
module pis_cfg_regs (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        soft_rst,
  input  wire logic        cfg_rd,
  input  wire logic        cfg_wr,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  output logic             cfg_rvalid,
  input  wire logic [31:0] config_command_status_reg,
  input  wire logic        aux_supply_sense_pin,
  input  wire logic        ee_load,
  input  wire logic [7:0]  ee_max_latency,
  input  wire logic [7:0]  ee_min_grant,
  input  wire logic        ee_wake_cold,
  input  wire logic        in_d3cold,
  output logic      [4:0]  wake_support_states
);
  logic [1:0]            rst_sync_r;
  logic                  rst_int_n;
  pis_pkg::pis_state_t   st_r;
  pis_pkg::pis_state_t   st_nxt;
  logic                  cold_rep;
  logic [31:0]           int_word;
  logic [31:0]           cap_word;
  logic                  cap_visible;
  logic                  hit_int;
  logic                  hit_cap;
  logic                  hit_ptr;

  // reset released through two flops
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_int_n = rst_sync_r[1];

  // losing aux hides cold wake as soon as the filter clears aux_ok, four edges after the pin drops; the stored bit survives
  assign cold_rep    = st_r.wake_cold_stored & st_r.aux_ok;
  // bit 4 clear hides the whole word; the pointer at 34h still reads 40h
  assign cap_visible = config_command_status_reg[pis_pkg::CAP_LIST_EN_BIT];
  assign wake_support_states = {cold_rep, pis_pkg::WAKE_WARM_STATES};

  // word decode ignores the byte offset; lanes come from cfg_be
  assign hit_int = cfg_addr[7:2] == pis_pkg::OFF_INT_SELECT[7:2];
  assign hit_cap = cfg_addr[7:2] == pis_pkg::OFF_PM_CAP[7:2];
  assign hit_ptr = cfg_addr[7:2] == pis_pkg::OFF_CAP_PTR[7:2];

  always_comb begin
    int_word = '0;
    int_word[pis_pkg::MAX_LAT_LSB +: 8]  = st_r.max_latency_desired;
    int_word[pis_pkg::MIN_GNT_LSB +: 8]  = st_r.min_grant_desired;
    int_word[pis_pkg::INT_PIN_LSB +: 8]  = pis_pkg::INT_PIN_CODE;
    int_word[pis_pkg::INT_LINE_LSB +: 8] = st_r.interrupt_line_number;
  end

  always_comb begin
    cap_word = '0;
    cap_word[pis_pkg::WAKE_LSB +: 5]     = wake_support_states;
    cap_word[pis_pkg::STATE_TWO_BIT]     = 1'b1;
    cap_word[pis_pkg::STATE_ONE_BIT]     = 1'b1;
    cap_word[pis_pkg::AUX_CUR_LSB +: 3]  = cold_rep ? pis_pkg::AUX_CURRENT_MAX
                                                    : pis_pkg::AUX_CURRENT_NONE;
    cap_word[pis_pkg::PM_VER_LSB +: 3]   = pis_pkg::PM_SPEC_VERSION;
    cap_word[pis_pkg::NEXT_PTR_LSB +: 8] = pis_pkg::NEXT_CAP_POINTER;
    cap_word[pis_pkg::CAP_ID_LSB +: 8]   = pis_pkg::CAP_IDENTIFIER;
  end

  always_comb begin
    st_nxt = st_r;
    // first sync flop feeds only the second
    st_nxt.aux_sync = {st_r.aux_sync[1:0], aux_supply_sense_pin};
    // glitch filter: accept only once stages two and three agree
    if (st_r.aux_sync[1] == st_r.aux_sync[2]) begin
      st_nxt.aux_ok = st_r.aux_sync[2];
    end
    // the host cannot write latency or grant; only the eeprom can
    if (ee_load) begin
      st_nxt.max_latency_desired = ee_max_latency;
      st_nxt.min_grant_desired   = ee_min_grant;
      if (in_d3cold) begin
        st_nxt.wake_cold_stored = ee_wake_cold;
      end
    end
    // only the line byte is writable; other bytes are dropped
    if (cfg_wr && cfg_addr[7:2] == pis_pkg::OFF_INT_SELECT[7:2] && cfg_be[0]) begin
      st_nxt.interrupt_line_number = cfg_wdata[pis_pkg::INT_LINE_LSB +: 8];
    end
    // read and write in one cycle: the read sees the old word
    st_nxt.rvalid = cfg_rd;
    if (cfg_rd) begin
      if (cfg_addr[7:2] == pis_pkg::OFF_INT_SELECT[7:2]) begin
        st_nxt.rdata = int_word;
      end else if (cfg_addr[7:2] == pis_pkg::OFF_PM_CAP[7:2]) begin
        st_nxt.rdata = cap_visible ? cap_word : 32'h0;
      end else if (cfg_addr[7:2] == pis_pkg::OFF_CAP_PTR[7:2]) begin
        st_nxt.rdata = {24'h0, pis_pkg::CAP_LIST_OFFSET};
      end else begin
        st_nxt.rdata = 32'h0;
      end
    end
  end

  // soft_rst is deliberately not used: both words survive it
  always_ff @(posedge ref_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      st_r.max_latency_desired   <= pis_pkg::MAX_LATENCY_RST;
      st_r.min_grant_desired     <= pis_pkg::MIN_GRANT_RST;
      st_r.interrupt_line_number <= pis_pkg::INT_LINE_RST;
      st_r.wake_cold_stored      <= pis_pkg::WAKE_COLD_RST;
      // pre-filled to the reset aux level, so no false drop follows reset
      st_r.aux_sync              <= {3{pis_pkg::AUX_OK_RST}};
      st_r.aux_ok                <= pis_pkg::AUX_OK_RST;
      st_r.rdata                 <= 32'h0;
      st_r.rvalid                <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // one register feeds the read port, so data stands until the next read
  assign cfg_rdata  = st_r.rdata;
  assign cfg_rvalid = st_r.rvalid;

  // checks are off while the internal reset is held
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_int_n);

  int_pin_const_a: assert property (
    cfg_rd && cfg_addr[7:2] == pis_pkg::OFF_INT_SELECT[7:2]
    |=> cfg_rvalid && cfg_rdata[15:8] == 8'h01)
    else $error("interrupt pin byte not 01h");

  line_write_back_a: assert property (
    cfg_wr && cfg_be[0] && cfg_addr[7:2] == pis_pkg::OFF_INT_SELECT[7:2]
    |=> int_word[7:0] == $past(cfg_wdata[7:0]))
    else $error("interrupt line not read back");

  ro_write_ignored_a: assert property (
    cfg_wr && !ee_load |=> $stable(st_r.max_latency_desired)
      && $stable(st_r.min_grant_desired) && $stable(st_r.wake_cold_stored))
    else $error("write changed a read-only field");

  ee_load_grant_a: assert property (
    ee_load |=> st_r.max_latency_desired == $past(ee_max_latency)
      && st_r.min_grant_desired == $past(ee_min_grant))
    else $error("eeprom load of latency or grant lost");

  cold_load_gate_a: assert property (
    ee_load && !in_d3cold |=> $stable(st_r.wake_cold_stored))
    else $error("cold wake bit loaded outside D3cold");

  cap_hidden_a: assert property (
    cfg_rd && cfg_addr[7:2] == pis_pkg::OFF_PM_CAP[7:2] && !cap_visible
    |=> cfg_rdata == 32'h0)
    else $error("capability word visible with bit4 clear");

  cap_fields_a: assert property (
    cfg_rd && cfg_addr[7:2] == pis_pkg::OFF_PM_CAP[7:2] && cap_visible
    |=> cfg_rdata[26:25] == 2'h3 && cfg_rdata[18:16] == 3'h2
      && cfg_rdata[15:0] == 16'h0001 && cfg_rdata[30:27] == 4'hf)
    else $error("fixed capability fields wrong");

  aux_current_a: assert property (
    cfg_rd && cfg_addr[7:2] == pis_pkg::OFF_PM_CAP[7:2] && cap_visible
    |=> cfg_rdata[24:22] == (cfg_rdata[31] ? 3'h6 : 3'h0))
    else $error("aux current does not follow cold wake");

  aux_loss_a: assert property (
    !aux_supply_sense_pin [*5] |-> !wake_support_states[4])
    else $error("cold wake reported without aux power");

  cap_ptr_a: assert property (
    cfg_rd && cfg_addr[7:2] == pis_pkg::OFF_CAP_PTR[7:2] |=> cfg_rdata == 32'h40)
    else $error("capability list offset not 40h");

  read_latency_a: assert property (
    cfg_rvalid == $past(cfg_rd))
    else $error("read answer not exactly one cycle after the request");

  // reset values show on the first edge after release
  lat_reset_a: assert property (
    $rose(rst_int_n) |-> int_word[31:24] == 8'h34)
    else $error("max latency reset value wrong");

  gnt_reset_a: assert property (
    $rose(rst_int_n) |-> int_word[23:16] == 8'h0b)
    else $error("min grant reset value wrong");

  reset_word_a: assert property (
    $rose(rst_int_n) |-> int_word == 32'h340b0100)
    else $error("interrupt select reset value wrong");

  cap_reset_a: assert property (
    $rose(rst_int_n) |-> cap_word == 32'hff820001)
    else $error("capability reset value wrong");

  cold_reset_a: assert property (
    $rose(rst_int_n) |-> wake_support_states == 5'h1f)
    else $error("wake field reset value wrong");

  // stored fields move only on their own strobe
  soft_keep_a: assert property (
    soft_rst && !ee_load && !cfg_wr |=> $stable(int_word))
    else $error("soft reset changed the interrupt select word");

  line_hold_a: assert property (
    !cfg_wr |=> $stable(st_r.interrupt_line_number))
    else $error("interrupt line changed without a write");

  line_mask_a: assert property (
    cfg_wr && hit_int && !cfg_be[0] |=> $stable(st_r.interrupt_line_number))
    else $error("line byte written without its byte enable");

  ee_no_line_a: assert property (
    ee_load && !cfg_wr |=> $stable(st_r.interrupt_line_number))
    else $error("eeprom load touched the interrupt line");

  ro_line_keep_a: assert property (
    cfg_wr && !hit_int |=> $stable(st_r.interrupt_line_number))
    else $error("write elsewhere changed the interrupt line");

  cold_load_a: assert property (
    ee_load && in_d3cold |=> st_r.wake_cold_stored == $past(ee_wake_cold))
    else $error("cold wake bit not loaded in D3cold");

  cold_hold_a: assert property (
    !ee_load |=> $stable(st_r.wake_cold_stored))
    else $error("cold wake bit changed without a load");

  grant_hold_a: assert property (
    !ee_load |=> $stable(st_r.max_latency_desired) && $stable(st_r.min_grant_desired))
    else $error("latency or grant changed without a load");

  // read path, against the stored state one edge earlier
  int_read_a: assert property (
    cfg_rd && hit_int |=> cfg_rdata == {$past(st_r.max_latency_desired),
      $past(st_r.min_grant_desired), 8'h01, $past(st_r.interrupt_line_number)})
    else $error("interrupt select read does not match the stored fields");

  wake_read_a: assert property (
    cfg_rd && hit_cap && cap_visible |=> cfg_rdata[31:27] == $past(wake_support_states))
    else $error("wake field read wrong");

  unmapped_zero_a: assert property (
    cfg_rd && !hit_int && !hit_cap && !hit_ptr |=> cfg_rdata == 32'h0)
    else $error("unmapped read not zero");

  rdata_hold_a: assert property (
    !cfg_rd |=> $stable(cfg_rdata))
    else $error("read data moved without a read");

  // a one-cycle dip on the aux pin must not reach the wake field
  aux_filter_a: assert property (
    st_r.aux_sync[1] != st_r.aux_sync[2] |=> $stable(st_r.aux_ok))
    else $error("aux sense accepted before two stages agree");

  aux_accept_a: assert property (
    st_r.aux_sync[1] == st_r.aux_sync[2] |=> st_r.aux_ok == $past(st_r.aux_sync[2]))
    else $error("aux sense not taken once stages agree");

  aux_return_a: assert property (
    aux_supply_sense_pin [*5] |-> st_r.aux_ok)
    else $error("aux power not accepted after settling");

  cov_line_write: cover property (
    cfg_wr && cfg_be[0] && cfg_addr[7:2] == pis_pkg::OFF_INT_SELECT[7:2]);
  cov_cap_read: cover property (
    cfg_rd && cfg_addr[7:2] == pis_pkg::OFF_PM_CAP[7:2] && cap_visible);
  cov_ee_cold: cover property (ee_load && in_d3cold);
  cov_aux_drop: cover property (wake_support_states[4] ##1 !wake_support_states[4]);
  cov_hidden_read: cover property (cfg_rd && hit_cap && !cap_visible);
endmodule

// ==== pis_tb.sv ====
// self-checking bench for the interrupt select and capability words
`timescale 1ns/1ns
module testbench;
  logic        ref_clk;
  logic        rst_n;
  logic        soft_rst;
  logic        cfg_rd;
  logic        cfg_wr;
  logic [7:0]  cfg_addr;
  logic [3:0]  cfg_be;
  logic [31:0] cfg_wdata;
  logic [31:0] cfg_rdata;
  logic        cfg_rvalid;
  logic [31:0] ccs;
  logic        aux;
  logic        ee_load;
  logic [7:0]  ee_lat;
  logic [7:0]  ee_gnt;
  logic        ee_cold;
  logic        d3cold;
  logic [4:0]  wake;
  int          bad_count;
  int          n_tests;
  int          cyc;

  pis_cfg_regs i_pis_cfg_regs (
    .ref_clk                   (ref_clk),
    .rst_n                     (rst_n),
    .soft_rst                  (soft_rst),
    .cfg_rd                    (cfg_rd),
    .cfg_wr                    (cfg_wr),
    .cfg_addr                  (cfg_addr),
    .cfg_be                    (cfg_be),
    .cfg_wdata                 (cfg_wdata),
    .cfg_rdata                 (cfg_rdata),
    .cfg_rvalid                (cfg_rvalid),
    .config_command_status_reg (ccs),
    .aux_supply_sense_pin      (aux),
    .ee_load                   (ee_load),
    .ee_max_latency            (ee_lat),
    .ee_min_grant              (ee_gnt),
    .ee_wake_cold              (ee_cold),
    .in_d3cold                 (d3cold),
    .wake_support_states       (wake)
  );

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic stop_test;
    if (bad_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // a hang costs at most a few thousand cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      stop_test;
    end
  end

  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_wake(input logic [4:0] e);
    n_tests++;
    if (wake !== e) begin
      bad_count++;
      $display("MISMATCH wake_support_states expected %h seen %h", e, wake);
    end
  endtask

  // rvalid stands one cycle, so it is looked at in that cycle
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(negedge ref_clk);
    cfg_rd = 1'b1;
    cfg_addr = a;
    @(negedge ref_clk);
    cfg_rd = 1'b0;
    chk_word("cfg_rvalid", 32'h1, {31'h0, cfg_rvalid});
    chk_word("cfg_rdata", e, cfg_rdata);
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(negedge ref_clk);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = d;
    @(negedge ref_clk);
    cfg_wr = 1'b0;
  endtask

  task automatic ee(input logic [7:0] l, input logic [7:0] g, input logic c, input logic d);
    @(negedge ref_clk);
    ee_load = 1'b1;
    {ee_lat, ee_gnt, ee_cold, d3cold} = {l, g, c, d};
    @(negedge ref_clk);
    ee_load = 1'b0;
  endtask

  // wait leaves room for the two-flop release and the aux filter
  task automatic hard_rst;
    rst_n = 1'b0;
    repeat (16) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (8) @(negedge ref_clk);
  endtask

  task automatic t_regs;
    rd(8'h3c, 32'h340b0100);
    rd(8'h40, 32'hff820001);
    rd(8'h34, 32'h00000040);
    rd(8'h50, 32'h0);
    chk_wake(5'h1f);
    wr(8'h3c, 4'hf, 32'hffffffa5);
    rd(8'h3c, 32'h340b01a5);
    wr(8'h3c, 4'he, 32'h0000005a);
    rd(8'h3c, 32'h340b01a5);
    wr(8'h40, 4'hf, 32'h0);
    rd(8'h40, 32'hff820001);
    wr(8'h34, 4'hf, 32'hffffffff);
    rd(8'h34, 32'h00000040);
    soft_rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    soft_rst = 1'b0;
    rd(8'h3c, 32'h340b01a5);
    ccs = 32'hffffffef;
    rd(8'h40, 32'h0);
    ccs = 32'h10;
  endtask

  task automatic t_eeprom;
    ee(8'h12, 8'h34, 1'b0, 1'b0);
    rd(8'h3c, 32'h123401a5);
    chk_wake(5'h1f);
    ee(8'h56, 8'h78, 1'b0, 1'b1);
    chk_wake(5'h0f);
    rd(8'h40, 32'h7e020001);
    ee(8'h34, 8'h0b, 1'b1, 1'b1);
    rd(8'h40, 32'hff820001);
    d3cold = 1'b0;
  endtask

  task automatic t_aux;
    @(negedge ref_clk);
    aux = 1'b0;
    @(negedge ref_clk);
    aux = 1'b1;
    repeat (6) @(negedge ref_clk);
    chk_wake(5'h1f);
    aux = 1'b0;
    repeat (8) @(negedge ref_clk);
    chk_wake(5'h0f);
    rd(8'h40, 32'h7e020001);
    aux = 1'b1;
    repeat (8) @(negedge ref_clk);
    chk_wake(5'h1f);
  endtask

  initial begin
    {rst_n, soft_rst, cfg_rd, cfg_wr, ee_load, ee_cold, d3cold} = '0;
    {cfg_addr, cfg_be, cfg_wdata, ee_lat, ee_gnt} = '0;
    ccs = 32'h10;
    aux = 1'b1;
    bad_count = 0;
    n_tests = 0;
    cyc = 0;
    hard_rst;
    t_regs;
    t_eeprom;
    t_aux;
    hard_rst;
    rd(8'h3c, 32'h340b0100);
    stop_test;
  end
endmodule
